// ==== common/twe_regs.svh ====
// Constants shared by both ends of the two-wire memory link
`ifndef TWE_REGS_SVH
`define TWE_REGS_SVH

`define TWE_TYPE_CODE 4'hA
`define TWE_BYTE_BITS 8
`define TWE_PAGE_BITS 5
`define TWE_ADDR_BITS 13
`define TWE_RECOVER_CLKS 9
`define TWE_SYS_CLK_KHZ 20000
`define TWE_WR_TIME_US 5000
`define TWE_WR_CYCLES (`TWE_WR_TIME_US * `TWE_SYS_CLK_KHZ / 1000)
`define TWE_QUARTER_DIV 13

`endif

// ==== common/twe_pkg.sv ====
// Types shared by both ends of the two-wire memory link
`default_nettype none
package twe_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE  = 3'b000,
        DEV_ADDR  = 3'b001,
        DEV_AHI   = 3'b010,
        DEV_ALO   = 3'b011,
        DEV_WDATA = 3'b100,
        DEV_RDATA = 3'b101
    } twe_dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE  = 3'b000,
        HST_START = 3'b001,
        HST_BIT   = 3'b010,
        HST_STOP  = 3'b011,
        HST_RCV   = 3'b100
    } twe_host_state_t;

    typedef enum logic [1:0] {
        CMD_WRITE   = 2'b00,
        CMD_READ    = 2'b01,
        CMD_RECOVER = 2'b10
    } twe_cmd_t;

endpackage
`default_nettype wire

// ==== common/twe_if.sv ====
// Open-drain two-wire link joining the host end and the memory end
`default_nettype none
interface twe_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;

    // Pull-up wins unless an enabled driver pulls low
    assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

    modport host (
        output scl,
        output sda_host_o,
        output sda_host_oe,
        input sda
    );

    modport dev (
        input scl,
        input sda,
        output sda_dev_o,
        output sda_dev_oe
    );
endinterface
`default_nettype wire

// ==== verilog/twe_dev.sv ====
// Memory end: serial slave, access sequencer and write-cycle timer
`include "twe_regs.svh"
`default_nettype none
module twe_dev #(
    parameter int AW = `TWE_ADDR_BITS,
    parameter int unsigned WR_CYCLES = `TWE_WR_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link
    twe_if.dev link,
    // Straps and protection pins
    input wire logic strap_select_bit2,
    input wire logic strap_select_bit1,
    input wire logic strap_select_bit0,
    input wire logic write_protect,
    // Status
    output logic standby,
    output logic write_busy
);
    localparam int PB = `TWE_PAGE_BITS;

    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [2:0] strap);
        addr_match = (b[7:4] == `TWE_TYPE_CODE) && (b[3:1] == strap);
    endfunction

    twe_pkg::twe_dev_state_t st_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic [7:0] ahi_r;
    logic [AW-1:0] addr_r;
    logic ack_r;
    logic wr_pend_r;
    logic sda_oe_r;
    logic [7:0] mem [2**AW];
    logic start_tog_r;
    logic stop_tog_r;
    logic start_cap_r;
    logic start_seen_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic busy_l1_r;
    logic busy_l2_r;
    logic [7:0] byte_in;
    logic [15:0] word_addr;
    logic start_new;
    logic mem_we;
    logic wp_s;
    logic [2:0] strap_s;

    assign byte_in = {sh_r[6:0], link.sda};
    assign word_addr = {ahi_r, byte_in};
    assign start_new = start_cap_r != start_seen_r;
    assign wp_s = pin_s2_r[3];
    assign strap_s = pin_s2_r[2:0];
    assign mem_we = !start_new && cnt_r == 4'h7 &&
                    st_r == twe_pkg::DEV_WDATA && !wp_s;
    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = sda_oe_r;

    // Bus conditions: the data line itself clocks these two toggles
    always_ff @(negedge link.sda or negedge nrst)
    begin
        if (!nrst)
            start_tog_r <= 1'b0;
        else if (link.scl)
            start_tog_r <= ~start_tog_r;
    end

    always_ff @(posedge link.sda or negedge nrst)
    begin
        if (!nrst)
            stop_tog_r <= 1'b0;
        else if (link.scl)
            stop_tog_r <= ~stop_tog_r;
    end

    // Pins and busy level into the link domain
    always_ff @(posedge link.scl or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            busy_l1_r <= 1'b0;
            busy_l2_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= {write_protect, strap_select_bit2,
                         strap_select_bit1, strap_select_bit0};
            pin_s2_r <= pin_s1_r;
            busy_l1_r <= write_busy;
            busy_l2_r <= busy_l1_r;
        end
    end

    // Receive side and sequencer, sampled on the rising clock
    always_ff @(posedge link.scl or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= twe_pkg::DEV_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ahi_r <= 8'h00;
            addr_r <= '0;
            ack_r <= 1'b0;
            wr_pend_r <= 1'b0;
            start_seen_r <= 1'b0;
        end
        else if (start_new)
        begin
            start_seen_r <= start_cap_r;
            st_r <= twe_pkg::DEV_ADDR;
            cnt_r <= 4'h1;
            sh_r <= {7'h00, link.sda};
            ack_r <= 1'b0;
            wr_pend_r <= 1'b0;
        end
        else if (cnt_r == 4'h8)
        begin
            cnt_r <= 4'h0;
            ack_r <= 1'b0;
            if (!ack_r && st_r == twe_pkg::DEV_RDATA)
            begin
                if (!link.sda)
                begin
                    tx_r <= mem[addr_r];
                    addr_r <= addr_r + 1'b1;
                end
                else
                    st_r <= twe_pkg::DEV_IDLE;
            end
        end
        else if (cnt_r == 4'h7)
        begin
            cnt_r <= 4'h8;
            sh_r <= byte_in;
            case (st_r)
                twe_pkg::DEV_ADDR:
                begin
                    // A polling address during the write cycle gets no ack
                    if (addr_match(byte_in, strap_s) && !busy_l2_r)
                    begin
                        ack_r <= 1'b1;
                        if (byte_in[0])
                        begin
                            st_r <= twe_pkg::DEV_RDATA;
                            tx_r <= mem[addr_r];
                            addr_r <= addr_r + 1'b1;
                        end
                        else
                            st_r <= twe_pkg::DEV_AHI;
                    end
                    else
                    begin
                        ack_r <= 1'b0;
                        st_r <= twe_pkg::DEV_IDLE;
                    end
                end
                twe_pkg::DEV_AHI:
                begin
                    ahi_r <= byte_in;
                    ack_r <= 1'b1;
                    st_r <= twe_pkg::DEV_ALO;
                end
                twe_pkg::DEV_ALO:
                begin
                    addr_r <= word_addr[AW-1:0];
                    ack_r <= 1'b1;
                    st_r <= twe_pkg::DEV_WDATA;
                end
                twe_pkg::DEV_WDATA:
                begin
                    ack_r <= 1'b1;
                    addr_r <= {addr_r[AW-1:PB],
                               addr_r[PB-1:0] + 1'b1};
                    if (!wp_s)
                        wr_pend_r <= 1'b1;
                end
                default:
                    ack_r <= 1'b0;
            endcase
        end
        else
        begin
            cnt_r <= cnt_r + 4'h1;
            sh_r <= byte_in;
        end
    end

    // Array; data is placed as each byte arrives, timer runs after stop
    always_ff @(posedge link.scl)
    begin
        if (mem_we)
            mem[addr_r] <= byte_in;
    end

    // Drive side, changed on the falling clock
    always_ff @(negedge link.scl or negedge nrst)
    begin
        if (!nrst)
        begin
            sda_oe_r <= 1'b0;
            start_cap_r <= 1'b0;
        end
        else
        begin
            start_cap_r <= start_tog_r;
            if (cnt_r == 4'h8)
                sda_oe_r <= ack_r;
            else if (st_r == twe_pkg::DEV_RDATA)
                sda_oe_r <= ~tx_r[3'h7 - cnt_r[2:0]];
            else
                sda_oe_r <= 1'b0;
        end
    end

    // System domain: frame tracking and self-timed write cycle
    logic start_s1_r;
    logic start_s2_r;
    logic start_old_r;
    logic stop_s1_r;
    logic stop_s2_r;
    logic stop_old_r;
    logic pend_s1_r;
    logic pend_s2_r;
    logic frame_r;
    logic busy_r;
    logic [31:0] wr_cnt_r;
    logic stop_ev;
    logic start_ev;

    assign start_ev = start_s2_r != start_old_r;
    assign stop_ev = stop_s2_r != stop_old_r;
    assign write_busy = busy_r;
    assign standby = ~(busy_r | frame_r);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_old_r <= 1'b0;
            stop_s1_r <= 1'b0;
            stop_s2_r <= 1'b0;
            stop_old_r <= 1'b0;
            pend_s1_r <= 1'b0;
            pend_s2_r <= 1'b0;
        end
        else
        begin
            start_s1_r <= start_tog_r;
            start_s2_r <= start_s1_r;
            start_old_r <= start_s2_r;
            stop_s1_r <= stop_tog_r;
            stop_s2_r <= stop_s1_r;
            stop_old_r <= stop_s2_r;
            pend_s1_r <= wr_pend_r;
            pend_s2_r <= pend_s1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            frame_r <= 1'b0;
        else if (stop_ev)
            frame_r <= 1'b0;
        else if (start_ev)
            frame_r <= 1'b1;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_r <= 1'b0;
            wr_cnt_r <= 32'h0000_0000;
        end
        else if (busy_r)
        begin
            if (wr_cnt_r == 32'h0000_0000)
                busy_r <= 1'b0;
            else
                wr_cnt_r <= wr_cnt_r - 32'h0000_0001;
        end
        else if (stop_ev && pend_s2_r)
        begin
            busy_r <= 1'b1;
            wr_cnt_r <= 32'(WR_CYCLES - 1);
        end
    end
endmodule
`default_nettype wire

// ==== verilog/twe_host.sv ====
// Host end: byte-level two-wire master with clock divider and recovery
`include "twe_regs.svh"
`default_nettype none
module twe_host #(
    parameter int QDIV = `TWE_QUARTER_DIV
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link
    twe_if.host link,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire twe_pkg::twe_cmd_t cmd_kind,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_last,
    input wire logic [7:0] cmd_data,
    // Response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);
    twe_pkg::twe_host_state_t st_r;
    twe_pkg::twe_cmd_t kind_r;
    logic [7:0] div_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [3:0] rcv_r;
    logic [7:0] sh_r;
    logic stop_r;
    logic last_r;
    logic scl_r;
    logic oe_r;
    logic sda_s1_r;
    logic sda_s2_r;
    logic tick;

    assign tick = div_r == 8'(QDIV - 1);
    assign cmd_ready = st_r == twe_pkg::HST_IDLE;
    assign link.scl = scl_r;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = oe_r;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end
        else
        begin
            sda_s1_r <= link.sda;
            sda_s2_r <= sda_s1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            div_r <= 8'h00;
        else if (st_r == twe_pkg::HST_IDLE || tick)
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    // Quarter 0 lowers SCL, 1 moves SDA, 2 raises SCL, 3 samples or moves SDA for start and stop
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= twe_pkg::HST_IDLE;
            kind_r <= twe_pkg::CMD_WRITE;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            rcv_r <= 4'h0;
            sh_r <= 8'h00;
            stop_r <= 1'b0;
            last_r <= 1'b0;
            scl_r <= 1'b1;
            oe_r <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_ack <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (st_r == twe_pkg::HST_IDLE)
            begin
                if (cmd_valid)
                begin
                    kind_r <= cmd_kind;
                    stop_r <= cmd_stop;
                    last_r <= cmd_last;
                    sh_r <= cmd_data;
                    q_r <= 2'h0;
                    bit_r <= 4'h0;
                    rcv_r <= 4'h0;
                    if (cmd_kind == twe_pkg::CMD_RECOVER)
                        st_r <= twe_pkg::HST_RCV;
                    else if (cmd_start)
                        st_r <= twe_pkg::HST_START;
                    else
                        st_r <= twe_pkg::HST_BIT;
                end
            end
            else if (tick)
            begin
                q_r <= q_r + 2'h1;
                case (q_r)
                    2'h0:
                        scl_r <= 1'b0;
                    2'h1:
                    begin
                        case (st_r)
                            twe_pkg::HST_STOP:
                                oe_r <= 1'b1;
                            twe_pkg::HST_BIT:
                                if (bit_r == 4'h8)
                                    oe_r <= kind_r == twe_pkg::CMD_READ &&
                                            !last_r;
                                else
                                    oe_r <= kind_r == twe_pkg::CMD_WRITE &&
                                            !sh_r[7];
                            default:
                                oe_r <= 1'b0;
                        endcase
                    end
                    2'h2:
                        scl_r <= 1'b1;
                    default:
                    begin
                        case (st_r)
                            twe_pkg::HST_START:
                            begin
                                oe_r <= 1'b1;
                                st_r <= kind_r == twe_pkg::CMD_RECOVER ?
                                        twe_pkg::HST_STOP : twe_pkg::HST_BIT;
                            end
                            twe_pkg::HST_STOP:
                            begin
                                oe_r <= 1'b0;
                                st_r <= twe_pkg::HST_IDLE;
                                if (kind_r == twe_pkg::CMD_RECOVER)
                                begin
                                    rsp_valid <= 1'b1;
                                    rsp_ack <= 1'b1;
                                end
                            end
                            twe_pkg::HST_RCV:
                            begin
                                rcv_r <= rcv_r + 4'h1;
                                if (sda_s2_r ||
                                    rcv_r == 4'(`TWE_RECOVER_CLKS - 1))
                                    st_r <= twe_pkg::HST_START;
                            end
                            twe_pkg::HST_BIT:
                            begin
                                bit_r <= bit_r + 4'h1;
                                if (bit_r != 4'h8)
                                    sh_r <= {sh_r[6:0], sda_s2_r};
                                else
                                begin
                                    rsp_valid <= 1'b1;
                                    rsp_data <= sh_r;
                                    rsp_ack <= kind_r == twe_pkg::CMD_READ ?
                                               !last_r : !sda_s2_r;
                                    st_r <= stop_r ? twe_pkg::HST_STOP :
                                            twe_pkg::HST_IDLE;
                                end
                            end
                            default:
                                st_r <= twe_pkg::HST_IDLE;
                        endcase
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/twe_link_monitor.sv ====
// Wire-level checker of the two-wire link between both ends
`default_nettype none
module twe_link_monitor #(
    parameter int QDIV = 13
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link
    input wire logic scl,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD_MAX = 2 * QDIV;
    logic scl_q_r;
    logic sda_q_r;
    logic frame_r;
    logic first_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] addr_r;
    logic [7:0] low_cnt_r;
    logic start_w;
    logic stop_w;
    logic rise_w;

    assign start_w = scl & scl_q_r & sda_q_r & ~sda;
    assign stop_w = scl & scl_q_r & ~sda_q_r & sda;
    assign rise_w = scl & ~scl_q_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_q_r <= 1'h1;
            sda_q_r <= 1'h1;
        end
        else
        begin
            scl_q_r <= scl;
            sda_q_r <= sda;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            frame_r <= 1'h0;
        else if (start_w | stop_w)
            frame_r <= start_w;
    end

    // Bit position within the byte; first_r marks the address word
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_r <= 4'h0;
            first_r <= 1'h0;
        end
        else if (start_w)
        begin
            bit_cnt_r <= 4'h0;
            first_r <= 1'h1;
        end
        else if (rise_w)
        begin
            bit_cnt_r <= (bit_cnt_r == 4'h9) ? 4'h1 : bit_cnt_r + 4'h1;
            first_r <= first_r & (bit_cnt_r != 4'h9);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            addr_r <= 8'h00;
        else if (rise_w && first_r && bit_cnt_r < 4'h8)
            addr_r <= {addr_r[6:0], sda};
    end

    // Saturates so a parked low clock cannot wrap the count
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt_r <= 8'h00;
        else if (scl)
            low_cnt_r <= 8'h00;
        else if (low_cnt_r != 8'hFF)
            low_cnt_r <= low_cnt_r + 8'h01;
    end

    sequence seq_scl_held;
        scl [*2];
    endsequence

    chk_dev_hold_high: assert property (
        scl && $past(scl) |-> $stable(sda_dev_oe))
        else $error("device data moved while clock high");
    chk_host_data_low: assert property (
        $changed(sda_host_oe) && !start_w && !stop_w |-> !scl)
        else $error("host data moved while clock high");
    chk_dev_after_fall: assert property (
        $changed(sda_dev_oe) |-> !scl && low_cnt_r <= QDIV)
        else $error("device data not launched after clock fall");
    chk_addr_quiet: assert property (
        frame_r && first_r && bit_cnt_r < 4'h8 |-> !sda_dev_oe)
        else $error("device drove line during address word");
    chk_bad_type_nack: assert property (
        // Skip the rise that opens a stop: the host already holds SDA low
        scl && scl_q_r && first_r && bit_cnt_r == 4'h9 &&
        addr_r[7:4] != 4'hA |-> sda)
        else $error("device acked a foreign type code");
    chk_idle_quiet: assert property (
        !frame_r |-> !sda_dev_oe)
        else $error("device drove line outside a frame");
    chk_start_hold: assert property (
        start_w |-> seq_scl_held ##[1:HOLD_MAX] !scl)
        else $error("clock not held then lowered after start");
    chk_stop_free: assert property (
        stop_w |-> sda [*4])
        else $error("bus not left free after stop");
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Bench joining the host end and the memory end over the link
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QDIV = 6;
    localparam logic [7:0] DEV_W = 8'hAA;
    localparam logic [7:0] DEV_R = 8'hAB;
    logic sys_clk = 1'h0;
    logic nrst = 1'h0;
    logic cmd_valid = 1'h0;
    twe_pkg::twe_cmd_t cmd_kind = twe_pkg::CMD_WRITE;
    logic cmd_start = 1'h0;
    logic cmd_stop = 1'h0;
    logic cmd_last = 1'h0;
    logic [7:0] cmd_data = 8'h00;
    logic [2:0] strap_sel = 3'h5;
    logic write_protect = 1'h0;
    logic cmd_ready, rsp_valid, rsp_ack, standby, write_busy;
    logic [7:0] rsp_data;
    logic got_ack;
    logic [7:0] got_data;
    int bad_count = 0;
    int checks_done = 0;

    twe_if link ();
    twe_host #(.QDIV(QDIV)) u_twe_host (.sys_clk(sys_clk), .nrst(nrst),
        .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_kind(cmd_kind), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
        .cmd_last(cmd_last), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    twe_dev #(.WR_CYCLES(400)) u_twe_dev (.sys_clk(sys_clk), .nrst(nrst),
        .link(link), .strap_select_bit2(strap_sel[2]),
        .strap_select_bit1(strap_sel[1]), .strap_select_bit0(strap_sel[0]),
        .write_protect(write_protect), .standby(standby),
        .write_busy(write_busy));
    twe_link_monitor #(.QDIV(QDIV)) u_twe_link_monitor (.sys_clk(sys_clk),
        .nrst(nrst), .scl(link.scl), .sda_host_o(link.sda_host_o),
        .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o),
        .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));

    always #25 sys_clk = ~sys_clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic xfer(input twe_pkg::twe_cmd_t k, input logic [7:0] d,
        input logic s, input logic p, input logic l);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmd_kind = k;
        cmd_data = d;
        cmd_start = s;
        cmd_stop = p;
        cmd_last = l;
        cmd_valid = 1'h1;
        while (cmd_ready !== 1'h1 && n < 4000)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        cmd_valid = 1'h0;
        while (rsp_valid !== 1'h1 && n < 4000)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("response", 1'h1, n < 4000)
        got_ack = rsp_ack;
        got_data = rsp_data;
    endtask

    task automatic wr(input logic [7:0] d, input logic s, input logic p);
        xfer(twe_pkg::CMD_WRITE, d, s, p, 1'h0);
    endtask

    task automatic rd(input logic [7:0] exp, input logic last);
        xfer(twe_pkg::CMD_READ, 8'h00, 1'h0, last, last);
        `CHK("read byte", exp, got_data)
    endtask

    // High byte may carry bits above the array width
    task automatic seek(input logic [15:0] a);
        wr(DEV_W, 1'h1, 1'h0);
        `CHK("address ack", 1'h1, got_ack)
        wr(a[15:8], 1'h0, 1'h0);
        `CHK("word high ack", 1'h1, got_ack)
        wr(a[7:0], 1'h0, 1'h0);
        `CHK("word low ack", 1'h1, got_ack)
    endtask

    task automatic seek_read(input logic [15:0] a);
        seek(a);
        wr(DEV_R, 1'h1, 1'h0);
        `CHK("read address ack", 1'h1, got_ack)
    endtask

    // First try lands inside the write cycle and must be refused
    task automatic poll();
        int i;
        wr(DEV_W, 1'h1, 1'h1);
        `CHK("busy nack", 1'h0, got_ack)
        for (i = 0; i < 20 && got_ack !== 1'h1; i++)
            wr(DEV_W, 1'h1, 1'h1);
        `CHK("poll ack", 1'h1, got_ack)
    endtask

    task automatic t_write_read();
        seek(16'h0123);
        wr(8'h5A, 1'h0, 1'h0);
        `CHK("data ack", 1'h1, got_ack)
        wr(8'hA5, 1'h0, 1'h1);
        `CHK("data ack", 1'h1, got_ack)
        repeat (QDIV * 6) @(negedge sys_clk);
        `CHK("write busy", 1'h1, write_busy)
        `CHK("standby", 1'h0, standby)
        poll();
        repeat (QDIV * 6) @(negedge sys_clk);
        `CHK("standby", 1'h1, standby)
        seek_read(16'h0123);
        rd(8'h5A, 1'h1);
        wr(DEV_R, 1'h1, 1'h0);
        `CHK("current read ack", 1'h1, got_ack)
        rd(8'hA5, 1'h1);
        $display("test write_read done");
    endtask

    task automatic t_page_wrap();
        int i;
        seek(16'h003E);
        for (i = 0; i < 4; i++)
        begin
            wr(8'h10 + 8'(i), 1'h0, i == 3);
            `CHK("page ack", 1'h1, got_ack)
        end
        poll();
        seek_read(16'h003E);
        rd(8'h10, 1'h0);
        rd(8'h11, 1'h1);
        seek_read(16'h0020);
        rd(8'h12, 1'h0);
        rd(8'h13, 1'h1);
        $display("test page_wrap done");
    endtask

    task automatic t_top_wrap();
        seek(16'hE000);
        wr(8'h3C, 1'h0, 1'h1);
        poll();
        seek(16'h1FFF);
        wr(8'hC3, 1'h0, 1'h1);
        poll();
        seek_read(16'h1FFF);
        rd(8'hC3, 1'h0);
        rd(8'h3C, 1'h1);
        $display("test top_wrap done");
    endtask

    task automatic t_reject();
        logic [7:0] bad [5] = '{8'h2A, 8'hEA, 8'hA2, 8'hAE, 8'hA8};
        foreach (bad[i])
        begin
            wr(bad[i], 1'h1, 1'h1);
            `CHK("foreign nack", 1'h0, got_ack)
        end
        wr(DEV_W, 1'h1, 1'h1);
        `CHK("own ack", 1'h1, got_ack)
        @(negedge sys_clk);
        strap_sel = 3'h2;
        wr(8'hA4, 1'h1, 1'h1);
        `CHK("new strap ack", 1'h1, got_ack)
        wr(DEV_W, 1'h1, 1'h1);
        `CHK("old strap nack", 1'h0, got_ack)
        strap_sel = 3'h5;
        $display("test reject done");
    endtask

    task automatic t_protect();
        @(negedge sys_clk);
        write_protect = 1'h1;
        seek(16'h0123);
        wr(8'hFF, 1'h0, 1'h1);
        `CHK("protected ack", 1'h1, got_ack)
        repeat (QDIV * 6) @(negedge sys_clk);
        `CHK("no write cycle", 1'h0, write_busy)
        write_protect = 1'h0;
        seek_read(16'h0123);
        rd(8'h5A, 1'h1);
        $display("test protect done");
    endtask

    // Frame cut after the high byte, then the bus is recovered
    task automatic t_recover();
        wr(DEV_W, 1'h1, 1'h0);
        wr(8'h01, 1'h0, 1'h0);
        xfer(twe_pkg::CMD_RECOVER, 8'h00, 1'h0, 1'h0, 1'h0);
        `CHK("recover", 1'h1, got_ack)
        seek_read(16'h0123);
        rd(8'h5A, 1'h1);
        $display("test recover done");
    endtask

    initial
    begin
        repeat (3) @(negedge sys_clk);
        `CHK("standby in reset", 1'h1, standby)
        nrst = 1'h1;
        t_write_read();
        t_page_wrap();
        t_top_wrap();
        t_reject();
        t_protect();
        t_recover();
        end_of_test();
    end

    initial
    begin
        #(50 * 90000);
        $display("watchdog expired");
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
